/* File: inc/cfg_pkg.sv */
package cfg_pkg;
   // Register byte addresses on the internal command bus
   localparam logic [7:0] CH0_FILTER_RATE_SHIFT_ADDR = 8'h40;
   localparam logic [7:0] CH0_GAIN_MULTIPLIER_ADDR = 8'h41;
   localparam logic [7:0] CH1_FILTER_RATE_SHIFT_ADDR = 8'h48;
   localparam logic [7:0] CH1_GAIN_MULTIPLIER_ADDR = 8'h49;
   localparam logic [7:0] FILTER_RATE_SHIFT_RESET = 8'h00;
   localparam logic [7:0] GAIN_MULTIPLIER_RESET = 8'h00;

   // Field positions in the filter/rate/shift register
   localparam int FILTER_SEL_LSB = 4;
   localparam int PERIOD_SEL_LSB = 2;
   localparam int SHIFT_SEL_LSB = 0;

   localparam int NUM_CHAN = 2;
   localparam int CHAN_STRIDE = 8;

   // Gain arithmetic: sens * shift * (256 + mult) / 256
   localparam logic [9:0] MULT_BASE = 10'h100;
   localparam int MULT_FRAC_BITS = 8;
   localparam int SHIFT_FRAC_BITS = 2;

   // Sample period in us per period code
   localparam int PERIOD_US_SHORT = 16;
   localparam int PERIOD_US_MID = 32;
   localparam int PERIOD_US_LONG = 64;
   localparam int CLK_MHZ = 25;
   localparam int PERIOD_CYC_SHORT = PERIOD_US_SHORT * CLK_MHZ;
   localparam int PERIOD_CYC_MID = PERIOD_US_MID * CLK_MHZ;
   localparam int PERIOD_CYC_LONG = PERIOD_US_LONG * CLK_MHZ;

   // Samples the data path needs to settle after a restart
   localparam logic [7:0] INIT_SAMPLES = 8'h10;

   // Filter type code: pole count and corner at the 16 us period, in 0.25 Hz units
   typedef struct packed {
      logic [1:0] poles_m2;
      logic [16:0] corner_q;
   } cfg_filter_t;

   typedef enum logic [1:0] {
      CFG_PER_16,
      CFG_PER_32,
      CFG_PER_64
   } cfg_period_t;
endpackage

/* File: design/cfg_filter_map.sv */
module cfg_filter_map
   import cfg_pkg::*;
(
   // Selection
   input wire logic [3:0] filter_select,
   input wire logic [1:0] sample_period_select,
   // Decoded result
   output logic [2:0] filter_poles,
   output logic [16:0] corner_quarter_hz,
   output cfg_period_t period
);
   logic [16:0] base_q;
   always_comb begin
      unique case (filter_select)
         4'h0, 4'h2: begin filter_poles = 3'h4; base_q = 17'd1600; end // R5
         4'h1, 4'h3: begin filter_poles = 3'h3; base_q = 17'd1600; end // R5
         4'h4: begin filter_poles = 3'h3; base_q = 17'd1300; end // R5
         4'h5: begin filter_poles = 3'h2; base_q = 17'd1480; end // R5
         4'h6: begin filter_poles = 3'h2; base_q = 17'd720; end // R5
         4'h7: begin filter_poles = 3'h2; base_q = 17'd400; end // R5
         4'h8: begin filter_poles = 3'h4; base_q = 17'd6000; end // R6
         4'h9: begin filter_poles = 3'h3; base_q = 17'd2000; end // R6
         4'ha: begin filter_poles = 3'h4; base_q = 17'd3200; end // R6
         4'hb: begin filter_poles = 3'h4; base_q = 17'd4800; end // R6
         4'hc: begin filter_poles = 3'h3; base_q = 17'd480; end // R6
         4'hd: begin filter_poles = 3'h2; base_q = 17'd80000; end // R6
         4'he: begin filter_poles = 3'h2; base_q = 17'd480; end // R6
         4'hf: begin filter_poles = 3'h4; base_q = 17'd200; end // R6
      endcase
      // Halving by shift is exact: every corner is a multiple of 1 Hz
      unique case (sample_period_select)
         2'b00, 2'b01: begin period = CFG_PER_16; corner_quarter_hz = base_q; end // R7
         2'b10: begin period = CFG_PER_32; corner_quarter_hz = base_q >> 1; end // R7
         2'b11: begin period = CFG_PER_64; corner_quarter_hz = base_q >> 2; end // R7
      endcase
   end
endmodule

/* File: design/cfg_gain_scale.sv */
module cfg_gain_scale
   import cfg_pkg::*;
(
   // Gain settings
   input wire logic [1:0] gain_shift_select,
   input wire logic [7:0] gain_multiplier,
   // Sensitivity factor, unsigned, 10 fraction bits
   output logic [12:0] gain_factor
);
   logic [9:0] mult_term;
   logic [12:0] shifted;
   always_comb begin
      mult_term = MULT_BASE + {2'b00, gain_multiplier}; // R12
      // Shift factor 0.25, 0.5, 1, 2 is 1 << code in quarter units
      shifted = {3'b000, mult_term} << gain_shift_select; // R13
      gain_factor = shifted; // R11
   end
endmodule

/* File: design/cfg_chan_regs.sv */
// Functional notes
// [R1] First register per channel: filter, period, shift
// [R2] Second register per channel: unsigned gain multiplier
// [R3] All four registers readable and writable all modes
// [R4] Registers covered by register array error check
// [R5] Filter codes 0-7 map to listed corners
// [R6] Filter codes 8-15 map to listed corners
// [R7] Period codes: 16, 16, 32, 64 us
// [R8] Filter or period change restarts channel DSP
// [R9] Results not valid until initialization completes
// [R10] Host avoids result reads during initialization
// [R11] Sensitivity scaled by shift and multiplier
// [R12] Factor is shift times (256+mult)/256
// [R13] Shift codes give 0.25, 0.5, 1, 2
// [R14] Channels configured fully independently
module cfg_chan_regs
   import cfg_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Register access from the command interfaces
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   // Array check: parity over all four registers
   output logic cfg_parity,
   // Channel 0 signal chain
   output logic [2:0] ch0_filter_poles,
   output logic [16:0] ch0_corner_quarter_hz,
   output logic [1:0] ch0_period,
   output logic [12:0] ch0_gain_factor,
   output logic ch0_dsp_restart,
   output logic ch0_dsp_ready,
   output logic ch0_sample_tick,
   // Channel 1 signal chain
   output logic [2:0] ch1_filter_poles,
   output logic [16:0] ch1_corner_quarter_hz,
   output logic [1:0] ch1_period,
   output logic [12:0] ch1_gain_factor,
   output logic ch1_dsp_restart,
   output logic ch1_dsp_ready,
   output logic ch1_sample_tick
);
   logic [7:0] chan_filter_rate_shift [NUM_CHAN];
   logic [7:0] chan_gain_multiplier [NUM_CHAN];
   logic [2:0] poles [NUM_CHAN];
   logic [16:0] corner [NUM_CHAN];
   logic [1:0] period_q [NUM_CHAN];
   logic [12:0] gain [NUM_CHAN];
   logic restart [NUM_CHAN];
   logic ready [NUM_CHAN];
   logic tick [NUM_CHAN];
   logic [7:0] reg_rdata_q;
   logic reg_hit_q;
   logic cfg_parity_q;
   logic [7:0] next_reg_rdata;
   logic next_reg_hit;
   logic next_cfg_parity;

   genvar c;
   generate
      for (c = 0; c < NUM_CHAN; c++) begin : g_chan
         localparam logic [7:0] FRS_ADDR = CH0_FILTER_RATE_SHIFT_ADDR + 8'(c * CHAN_STRIDE);
         localparam logic [7:0] GM_ADDR = CH0_GAIN_MULTIPLIER_ADDR + 8'(c * CHAN_STRIDE);
         logic [7:0] next_frs;
         logic [7:0] next_gm;
         logic next_restart;
         logic [7:0] init_left;
         logic [7:0] next_init_left;
         logic [10:0] period_cnt;
         logic [10:0] next_period_cnt;
         logic [10:0] period_len;
         logic next_tick;
         logic [2:0] f_poles;
         logic [16:0] f_corner;
         cfg_period_t f_period;
         logic [12:0] f_gain;

         cfg_filter_map u_map (
            .filter_select(chan_filter_rate_shift[c][FILTER_SEL_LSB +: 4]),
            .sample_period_select(chan_filter_rate_shift[c][PERIOD_SEL_LSB +: 2]),
            .filter_poles(f_poles),
            .corner_quarter_hz(f_corner),
            .period(f_period)
         );

         cfg_gain_scale u_gain (
            .gain_shift_select(chan_filter_rate_shift[c][SHIFT_SEL_LSB +: 2]),
            .gain_multiplier(chan_gain_multiplier[c]),
            .gain_factor(f_gain)
         );

         always_comb begin
            next_frs = chan_filter_rate_shift[c];
            next_gm = chan_gain_multiplier[c];
            // Each channel decodes only its own addresses
            if (reg_wr && reg_addr == FRS_ADDR) begin // R1 R3 R14
               next_frs = reg_wdata;
            end
            if (reg_wr && reg_addr == GM_ADDR) begin // R2 R3 R14
               next_gm = reg_wdata;
            end
            // Shift-only writes leave the data path running
            next_restart = (next_frs[7:2] != chan_filter_rate_shift[c][7:2]); // R8
            unique case (f_period)
               CFG_PER_16: period_len = 11'(PERIOD_CYC_SHORT);
               CFG_PER_32: period_len = 11'(PERIOD_CYC_MID);
               CFG_PER_64: period_len = 11'(PERIOD_CYC_LONG);
               default: period_len = 11'(PERIOD_CYC_SHORT);
            endcase
            next_tick = 1'b0;
            next_period_cnt = period_cnt + 11'h001;
            next_init_left = init_left;
            if (next_restart) begin // R8
               next_period_cnt = 11'h000;
               next_init_left = INIT_SAMPLES;
            end else if (period_cnt >= period_len - 11'h001) begin // R7
               next_period_cnt = 11'h000;
               next_tick = 1'b1;
               if (init_left != 8'h00) begin
                  next_init_left = init_left - 8'h01;
               end
            end
         end

         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               chan_filter_rate_shift[c] <= FILTER_RATE_SHIFT_RESET;
               chan_gain_multiplier[c] <= GAIN_MULTIPLIER_RESET;
               restart[c] <= 1'b1;
               init_left <= INIT_SAMPLES;
               period_cnt <= 11'h000;
               tick[c] <= 1'b0;
               ready[c] <= 1'b0;
               poles[c] <= 3'h0;
               corner[c] <= 17'h00000;
               period_q[c] <= 2'h0;
               gain[c] <= 13'h0000;
            end else begin
               chan_filter_rate_shift[c] <= next_frs;
               chan_gain_multiplier[c] <= next_gm;
               restart[c] <= next_restart;
               init_left <= next_init_left;
               period_cnt <= next_period_cnt;
               tick[c] <= next_tick;
               ready[c] <= (next_init_left == 8'h00); // R9
               poles[c] <= f_poles;
               corner[c] <= f_corner;
               period_q[c] <= f_period;
               gain[c] <= f_gain; // R11
            end
         end
      end
   endgenerate

   always_comb begin
      next_reg_rdata = 8'h00;
      next_reg_hit = 1'b0;
      if (reg_rd) begin
         unique case (reg_addr)
            CH0_FILTER_RATE_SHIFT_ADDR: begin // R3
               next_reg_rdata = chan_filter_rate_shift[0];
               next_reg_hit = 1'b1;
            end
            CH0_GAIN_MULTIPLIER_ADDR: begin // R3
               next_reg_rdata = chan_gain_multiplier[0];
               next_reg_hit = 1'b1;
            end
            CH1_FILTER_RATE_SHIFT_ADDR: begin // R3
               next_reg_rdata = chan_filter_rate_shift[1];
               next_reg_hit = 1'b1;
            end
            CH1_GAIN_MULTIPLIER_ADDR: begin // R3
               next_reg_rdata = chan_gain_multiplier[1];
               next_reg_hit = 1'b1;
            end
            default: begin
               next_reg_rdata = 8'h00;
               next_reg_hit = 1'b0;
            end
         endcase
      end else if (reg_wr) begin
         next_reg_hit = (reg_addr == CH0_FILTER_RATE_SHIFT_ADDR)
            || (reg_addr == CH0_GAIN_MULTIPLIER_ADDR)
            || (reg_addr == CH1_FILTER_RATE_SHIFT_ADDR)
            || (reg_addr == CH1_GAIN_MULTIPLIER_ADDR);
      end
      // Registered parity lets the array checker compare against its stored copy
      next_cfg_parity = ^{chan_filter_rate_shift[0], chan_gain_multiplier[0],
         chan_filter_rate_shift[1], chan_gain_multiplier[1]}; // R4
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_q <= 8'h00;
         reg_hit_q <= 1'b0;
         cfg_parity_q <= 1'b0;
      end else begin
         reg_rdata_q <= next_reg_rdata;
         reg_hit_q <= next_reg_hit;
         cfg_parity_q <= next_cfg_parity;
      end
   end

   // Results are flagged invalid while ready is low; the host must hold off // R10
   assign reg_rdata = reg_rdata_q;
   assign reg_hit = reg_hit_q;
   assign cfg_parity = cfg_parity_q;
   assign ch0_filter_poles = poles[0];
   assign ch0_corner_quarter_hz = corner[0];
   assign ch0_period = period_q[0];
   assign ch0_gain_factor = gain[0];
   assign ch0_dsp_restart = restart[0];
   assign ch0_dsp_ready = ready[0];
   assign ch0_sample_tick = tick[0];
   assign ch1_filter_poles = poles[1];
   assign ch1_corner_quarter_hz = corner[1];
   assign ch1_period = period_q[1];
   assign ch1_gain_factor = gain[1];
   assign ch1_dsp_restart = restart[1];
   assign ch1_dsp_ready = ready[1];
   assign ch1_sample_tick = tick[1];
endmodule

/* File: bench/cfg_chan_checker.sv */
module cfg_chan_checker
   import cfg_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Register access
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit,
   // Channel status
   input wire logic [1:0] ch0_period,
   input wire logic ch0_dsp_restart,
   input wire logic ch0_dsp_ready,
   input wire logic ch0_sample_tick,
   input wire logic ch1_dsp_restart,
   input wire logic ch1_dsp_ready
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic [1:0] up;
   logic [10:0] gap;
   logic gap_ok;
   logic map;
   // Mask keeps 0x40, 0x41, 0x48, 0x49 and nothing else
   assign map = (reg_addr & 8'hf6) == 8'h40;
   // A restart voids the tick interval in flight, so it is not judged
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         up <= 2'h0;
         gap <= 11'h000;
         gap_ok <= 1'b0;
      end else begin
         up <= {up[0], 1'b1};
         gap <= ch0_sample_tick ? 11'h001 : gap + 11'h001;
         gap_ok <= (gap_ok || ch0_sample_tick) && !ch0_dsp_restart;
      end
   end
   hit_mapped_a: assert property ((reg_wr || reg_rd) && map |=> reg_hit)
      else $error("no hit after mapped access");
   hit_unmapped_a: assert property (!((reg_wr || reg_rd) && map) |=> !reg_hit)
      else $error("hit without mapped access");
   rd_unmapped_a: assert property (reg_rd && !map |=> reg_rdata == 8'h00)
      else $error("unmapped read data not zero");
   cause_ch0_a: assert property (ch0_dsp_restart && up[1] |-> $past(reg_wr && reg_addr == 8'h40))
      else $error("channel 0 restart without write");
   cause_ch1_a: assert property (ch1_dsp_restart && up[1] |-> $past(reg_wr && reg_addr == 8'h48))
      else $error("channel 1 restart without write");
   ready_ch0_a: assert property (ch0_dsp_restart |=> !ch0_dsp_ready [*8])
      else $error("channel 0 ready during init");
   ready_ch1_a: assert property (ch1_dsp_restart |=> !ch1_dsp_ready [*8])
      else $error("channel 1 ready during init");
   tick_gap_a: assert property (ch0_sample_tick && gap_ok |-> gap ==
      (ch0_period == 2'h0 ? 11'h190 : ch0_period == 2'h1 ? 11'h320 : 11'h640))
      else $error("sample tick spacing wrong");
   cover property (ch0_dsp_restart ##1 !ch0_dsp_ready);
   cover property ($rose(ch0_dsp_ready));
   cover property (reg_rd && !map ##1 !reg_hit);
endmodule

bind cfg_chan_regs cfg_chan_checker cfg_chan_checker_inst (.mclk(mclk), .resetn(resetn),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
   .reg_hit(reg_hit), .ch0_period(ch0_period), .ch0_dsp_restart(ch0_dsp_restart),
   .ch0_dsp_ready(ch0_dsp_ready), .ch0_sample_tick(ch0_sample_tick),
   .ch1_dsp_restart(ch1_dsp_restart), .ch1_dsp_ready(ch1_dsp_ready));

/* File: bench/cfg_host_model.sv */
module cfg_host_model (
   // Clock
   input wire logic mclk,
   // Register access
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   // Answer
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // Touches configuration registers only, never sensor results
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic h);
      @(posedge mclk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      // Released lines show the inverse, not a stale copy
      reg_addr <= ~a;
      reg_wdata <= ~d;
      #1;
      q = reg_rdata;
      h = reg_hit;
   endtask
endmodule

/* File: bench/tb.sv */
module tb
   import cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, resetn, reg_wr, reg_rd, reg_hit, cfg_parity, h;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, q, v;
   logic [2:0] p0, p1;
   logic [16:0] c0, c1;
   logic [1:0] pr0, pr1, e;
   logic [12:0] g0, g1;
   logic rs0, rs1, rd0, rd1, tk0, tk1;
   int bad_count = 0, n_compared = 0, cyc = 0, n;
   logic [16:0] corner [16] = '{17'h640, 17'h640, 17'h640, 17'h640, 17'h514, 17'h5c8,
      17'h2d0, 17'h190, 17'h1770, 17'h7d0, 17'hc80, 17'h12c0, 17'h1e0, 17'h13880,
      17'h1e0, 17'hc8};
   logic [2:0] poles [16] = '{3'h4, 3'h3, 3'h4, 3'h3, 3'h3, 3'h2, 3'h2, 3'h2,
      3'h4, 3'h3, 3'h4, 3'h4, 3'h3, 3'h2, 3'h2, 3'h4};
   logic [7:0] mult [3] = '{8'h00, 8'h80, 8'hff};
   cfg_chan_regs cfg_chan_regs_inst (.mclk(mclk), .resetn(resetn), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_hit(reg_hit), .cfg_parity(cfg_parity), .ch0_filter_poles(p0),
      .ch0_corner_quarter_hz(c0), .ch0_period(pr0), .ch0_gain_factor(g0),
      .ch0_dsp_restart(rs0), .ch0_dsp_ready(rd0), .ch0_sample_tick(tk0),
      .ch1_filter_poles(p1), .ch1_corner_quarter_hz(c1), .ch1_period(pr1),
      .ch1_gain_factor(g1), .ch1_dsp_restart(rs1), .ch1_dsp_ready(rd1),
      .ch1_sample_tick(tk1));
   cfg_host_model cfg_host_model_inst (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [16:0] s, input logic [16:0] x);
      n_compared++;
      if (s !== x) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      cfg_host_model_inst.acc(w, a, d, q, h);
   endtask
   // Cut a hang short well past the longest init wait
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      resetn = 1'b0;
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         xfer(1'b0, 8'h40 + 8'((i / 2) * 8 + i % 2), 8'h00);
         chk(17'({h, q}), 17'h100);
      end
      xfer(1'b1, 8'h42, 8'h5a);
      xfer(1'b0, 8'h42, 8'h00);
      chk(17'({h, q}), 17'h0);
      for (int i = 0; i < 64; i++) begin
         v = {6'(i), 2'(i)};
         e = v[3] ? v[3:2] - 2'h1 : 2'h0;
         xfer(1'b1, 8'h40, v);
         @(posedge mclk);
         #1;
         chk(17'(p0), 17'(poles[v[7:4]]));
         chk(c0, corner[v[7:4]] >> e);
         chk(17'({pr0, g0}), 17'({e, 13'h100 << v[1:0]}));
         chk(c1, 17'h640);
         xfer(1'b0, 8'h40, 8'h00);
         chk(17'({h, q, cfg_parity}), 17'({1'b1, v, ^v}));
      end
      for (int j = 0; j < 12; j++) begin
         xfer(1'b1, 8'h48, 8'(j % 4));
         chk(17'(rs1), 17'h0);
         xfer(1'b1, 8'h49, mult[j / 4]);
         @(posedge mclk);
         #1;
         chk(17'(g1), (17'h100 + 17'(mult[j / 4])) << (j % 4));
         chk(17'(g0), 17'h800);
         xfer(1'b0, 8'h49, 8'h00);
         chk(17'({h, q, cfg_parity}), 17'({1'b1, mult[j / 4], ^{2'(j), mult[j / 4]}}));
      end
      xfer(1'b1, 8'h40, 8'h80);
      chk(17'({rs0, rd0}), 17'h2);
      repeat (3000) @(posedge mclk);
      // Second change aborts the init in flight and restarts the count
      xfer(1'b1, 8'h40, 8'h9c);
      chk(17'({rs0, rd0}), 17'h2);
      n = 0;
      while (rd0 !== 1'b1 && n < 30000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk(17'(n), 17'(INIT_SAMPLES * PERIOD_CYC_LONG));
      chk(17'(rd1), 17'h1);
      chk(17'({p1, pr1}), 17'({3'h4, 2'h0}));
      // Measure one full channel 1 sample interval at the short period
      while (tk1 !== 1'b1) begin
         @(posedge mclk);
         #1;
      end
      n = 1;
      @(posedge mclk);
      #1;
      while (tk1 !== 1'b1 && n < 2000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk(17'(n), 17'(PERIOD_CYC_SHORT));
      // Period code change (00 to 01, both 16 us) on channel 1 alone must not disturb channel 0
      xfer(1'b1, 8'h48, 8'h04);
      chk(17'({rs1, rd1, rs0}), 17'h4);
      give_verdict();
   end
endmodule
